// File: src/csss_pkg.sv
package csss_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] PLL_CSR_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam int LOCK_BIT = 0;
  localparam int PLL_ENABLE_BIT_BIT = 1;
  localparam int T1SEL_LSB = 2;
  localparam int SAT_BIT = 4;
  localparam int ST_SRC_LSB = 0;
  localparam int ST_OWN_IN = 3;
  localparam int ST_OWN_OUT = 4;
  localparam int ST_AMP_LSB = 5;
  localparam int ST_FSM_LSB = 8;
  localparam int ST_MULT_LSB = 16;
  localparam int ST_SAT_LSB = 24;

  // ---------------------------------------------------------------
  // fuse defaults and fixed figures
  // ---------------------------------------------------------------
  localparam logic FUSE_PLL_CLOCK_FUSE_DFLT = 1'h1;
  localparam logic [3:0] FUSE_CLOCK_SOURCE_FUSES_DFLT = 4'h1;
  localparam logic [1:0] FUSE_SUT_DFLT = 2'h2;
  localparam logic [7:0] PLL_MULT = 8'h40;
  localparam logic [7:0] PCK_SAT_MHZ = 8'h46;
  localparam int CNT_W = 17;
  localparam logic [16:0] CK_6 = 17'h00006;
  localparam logic [16:0] CK_18 = 17'h00012;
  localparam logic [16:0] CK_258 = 17'h00102;
  localparam logic [16:0] CK_1K = 17'h00400;
  localparam logic [1:0] SAMPLE_WAIT = 2'h2;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_EXT_CLK = 3'h0,
    SRC_INT_RC = 3'h1,
    SRC_EXT_RC = 3'h2,
    SRC_LF_XTAL = 3'h3,
    SRC_XTAL = 3'h4,
    SRC_PLL = 3'h5
  } csss_src_type;

  typedef enum logic [2:0] {
    CK6 = 3'h0, CK18 = 3'h1, CK258 = 3'h2,
    CK1K = 3'h3, CK16K = 3'h4, CK32K = 3'h5
  } csss_ck_type;

  typedef enum logic [1:0] {
    DLY_NONE = 2'h0, DLY_4K = 2'h1, DLY_64K = 2'h2
  } csss_dly_type;

  typedef enum logic [1:0] {
    SLP_IDLE = 2'h0, SLP_ADC_NR = 2'h1, SLP_PWR_DOWN = 2'h2,
    SLP_STANDBY = 2'h3
  } csss_sleep_type;

  typedef enum logic [2:0] {
    ST_SAMPLE = 3'h0, ST_CLK_DLY = 3'h1, ST_RST_DLY = 3'h2,
    ST_RUN = 3'h3, ST_SLEEP = 3'h4
  } csss_state_type;

  localparam logic [1:0] AMP_LOW = 2'h0;
  localparam logic [1:0] AMP_MID = 2'h1;
  localparam logic [1:0] AMP_HIGH = 2'h2;
  localparam logic [1:0] AMP_NONE = 2'h3;

endpackage : csss_pkg

// File: src/csss_pll_if.sv
interface csss_pll_if;
  logic run;
  logic [1:0] ref_div;
  logic rc_tick;
  logic over_nominal;
  logic locked;
  logic saturated;
  modport ctl(output run, ref_div, rc_tick, over_nominal,
              input locked, saturated);
  modport pll(input run, ref_div, rc_tick, over_nominal,
              output locked, saturated);
endinterface // csss_pll_if

// File: src/csss_pll.sv
module csss_pll
  import csss_pkg::*;
#(
  parameter int unsigned LOCK_REFS = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control side
  csss_pll_if.pll pl
);

  if (LOCK_REFS < 1 || LOCK_REFS > 255) begin : g_bad_lock
    $error("LOCK_REFS must be 1 to 255");
  end

  logic [2:0] div_q;
  logic [7:0] lock_cnt_q;
  logic locked_q;
  logic sat_q;

  // ---------------------------------------------------------------
  // reference divider and lock detect
  // ---------------------------------------------------------------
  // divide rc down
  wire [2:0] div_last = 3'((4'h1 << pl.ref_div) - 4'h1);
  wire ref_tick = pl.rc_tick && (div_q == div_last);
  wire lock_done = (lock_cnt_q == 8'(LOCK_REFS));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 3'h0;
    end else if (!pl.run) begin
      div_q <= 3'h0;
    end else if (pl.rc_tick) begin
      div_q <= ref_tick ? 3'h0 : div_q + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_q <= 8'h00;
    end else if (!pl.run || pl.over_nominal) begin
      lock_cnt_q <= 8'h00;
    end else if (ref_tick && !lock_done) begin
      lock_cnt_q <= lock_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_q <= 1'h0;
      sat_q <= 1'h0;
    end else begin
      locked_q <= pl.run && !pl.over_nominal && lock_done;
      sat_q <= pl.run && pl.over_nominal;
    end
  end

  assign pl.locked = locked_q;
  assign pl.saturated = sat_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sat_unlock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pl.saturated |-> !pl.locked)
    else $error("saturated pll reports lock");

  pll_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !pl.run |=> !pl.locked && !pl.saturated)
    else $error("stopped pll still active");

endmodule // csss_pll

// File: src/csss_top.sv
// What this block does
// - core clock gated off stops all core activity.
// - timers and serial unit on io clock; async irq sense when gated.
// - program memory clock runs and stops with the core clock.
// - converter clock keeps running in adc noise reduction sleep while core and io are gated.
// - fast peripheral clock is 64 times a 1 MHz reference.
// - pll reference is rc oscillator divided down to 1 MHz.
// - second timer may count on fast clock or its prescaled form.
// - reference above nominal saturates fast clock, unlocked.
// - pll runs only when enable bit set or pll fuse is 0.
// - lock flag readable by software once pll is locked.
// - power-down and standby stop rc oscillator and pll.
// - source fuses and pll fuse pick the system clock source.
// - oscillator pin ownership follows the selected source.
// - wake from power-down waits a count of source cycles.
// - start from reset adds 0, 4096 or 65536 watchdog cycles.
// - fuse defaults: pll fuse 1, source 0001, start-up 10.
// - crystal mode upper source bits select amplifier range.
// - crystal start-up count 258, 1K or 16K from fuse triple.
// - crystal reset delay none, 4K or 64K from fuse triple.
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
module csss_top
  import csss_pkg::*;
#(
  parameter int unsigned WDT_4K_CYC = 4096,
  parameter int unsigned WDT_64K_CYC = 65536,
  parameter int unsigned CK_16K_CYC = 16384,
  parameter int unsigned CK_32K_CYC = 32768,
  parameter int unsigned LOCK_REFS = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // configuration fuses
  input wire logic pll_clock_fuse,
  input wire logic [3:0] clock_source_fuses,
  input wire logic [1:0] startup_time_fuses,
  // oscillator ticks and wake events
  input wire logic src_tick,
  input wire logic wdt_tick,
  input wire logic rc_tick,
  input wire logic wake_irq,
  input wire logic ref_above_nominal,
  // sleep request from core
  input wire logic sleep_req,
  input wire logic [1:0] sleep_mode,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // clock domain gating
  output logic core_clk_en_q,
  output logic io_clk_en_q,
  output logic flash_clk_en_q,
  output logic adc_clk_en_q,
  output logic async_irq_sense_q,
  output logic rc_osc_en_q,
  output logic pll_run_q,
  output logic [1:0] t1_clk_sel_q,
  // source and oscillator pins
  output logic [2:0] clk_src_q,
  output logic osc_in_own_q,
  output logic osc_out_own_q,
  output logic [1:0] amp_range_q
);

  localparam int unsigned CNT_MAX = 2 ** CNT_W;
  if (WDT_4K_CYC < 1 || WDT_64K_CYC < 1 || CK_16K_CYC < 1 ||
      CK_32K_CYC < 1 || WDT_4K_CYC >= CNT_MAX ||
      WDT_64K_CYC >= CNT_MAX || CK_16K_CYC >= CNT_MAX ||
      CK_32K_CYC >= CNT_MAX) begin : g_bad_cnt
    $error("start-up counts out of range");
  end

  // ---------------------------------------------------------------
  // decode functions
  // ---------------------------------------------------------------
  // source select
  function automatic csss_src_type src_of(input logic pk,
                                          input logic [3:0] cs);
    if (!pk) return (cs == 4'h1) ? SRC_PLL : SRC_INT_RC;
    if (cs == 4'h0) return SRC_EXT_CLK;
    if (cs <= 4'h4) return SRC_INT_RC;
    if (cs <= 4'h8) return SRC_EXT_RC;
    if (cs == 4'h9) return SRC_LF_XTAL;
    return SRC_XTAL;
  endfunction

  function automatic csss_ck_type ck_of(input csss_src_type s,
                                        input logic [2:0] k);
    case (s)
      SRC_XTAL: return (k <= 3'h1) ? CK258 : (k <= 3'h4) ? CK1K : CK16K;
      SRC_LF_XTAL: return (k[1:0] == 2'h0 || k[1:0] == 2'h1) ? CK1K
                          : CK32K;
      SRC_EXT_RC: return (k[1:0] == 2'h3) ? CK6 : CK18;
      default: return CK6;
    endcase
  endfunction

  function automatic csss_dly_type dly_of(input csss_src_type s,
                                          input logic [2:0] k);
    case (s)
      SRC_XTAL: begin
        if (k == 3'h2 || k == 3'h5) return DLY_NONE;
        if (k == 3'h0 || k == 3'h3 || k == 3'h6) return DLY_4K;
        return DLY_64K;
      end
      SRC_LF_XTAL: return (k[1:0] == 2'h0) ? DLY_4K : DLY_64K;
      SRC_EXT_RC: begin
        if (k[1:0] == 2'h0) return DLY_NONE;
        return (k[1:0] == 2'h2) ? DLY_64K : DLY_4K;
      end
      default: begin
        if (k[1:0] == 2'h0) return DLY_NONE;
        return (k[1:0] == 2'h1) ? DLY_4K : DLY_64K;
      end
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] ck_cycles(input csss_ck_type c);
    case (c)
      CK6: return CK_6;
      CK18: return CK_18;
      CK258: return CK_258;
      CK1K: return CK_1K;
      CK16K: return CNT_W'(CK_16K_CYC - 1) + 17'h00001;
      default: return CNT_W'(CK_32K_CYC - 1) + 17'h00001;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [4:0] s1_q, s2_q, s3_q;
  logic [6:0] f1_q, f2_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
      f1_q <= 7'h00;
      f2_q <= 7'h00;
    end else begin
      s1_q <= {ref_above_nominal, wake_irq, rc_tick, wdt_tick, src_tick};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f1_q <= {pll_clock_fuse, clock_source_fuses, startup_time_fuses};
      f2_q <= f1_q;
    end
  end

  wire src_edge = s2_q[0] && !s3_q[0];
  wire wdt_edge = s2_q[1] && !s3_q[1];
  wire rc_edge = s2_q[2] && !s3_q[2];
  wire wake = s2_q[3];
  wire over_nom = s2_q[4];

  // ---------------------------------------------------------------
  // fuse capture
  // ---------------------------------------------------------------
  csss_state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic fz_pk_q;
  logic [3:0] fz_cs_q;
  logic [1:0] fz_sut_q;
  logic rst_path_q, rst_path_d;
  csss_sleep_type mode_q;

  wire sample_done = (state_q == ST_SAMPLE) &&
                     (cnt_q[1:0] == SAMPLE_WAIT);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fz_pk_q <= FUSE_PLL_CLOCK_FUSE_DFLT;
      fz_cs_q <= FUSE_CLOCK_SOURCE_FUSES_DFLT;
      fz_sut_q <= FUSE_SUT_DFLT;
    end else if (sample_done) begin
      {fz_pk_q, fz_cs_q, fz_sut_q} <= f2_q;
    end
  end

  wire csss_src_type src = src_of(fz_pk_q, fz_cs_q);
  wire [2:0] su_key = {fz_cs_q[0], fz_sut_q};
  wire [CNT_W-1:0] ck_target = ck_cycles(ck_of(src, su_key));
  wire csss_dly_type dly = dly_of(src, su_key);
  wire [CNT_W-1:0] dly_target = (dly == DLY_4K) ?
    CNT_W'(WDT_4K_CYC - 1) + 17'h00001 :
    CNT_W'(WDT_64K_CYC - 1) + 17'h00001;
  wire deep_mode = (mode_q == SLP_PWR_DOWN) || (mode_q == SLP_STANDBY);

  // ---------------------------------------------------------------
  // start-up and sleep sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    rst_path_d = rst_path_q;
    case (state_q)
      ST_SAMPLE: begin
        cnt_d = sample_done ? '0 : cnt_q + 17'h00001;
        if (sample_done) state_d = ST_CLK_DLY;
      end
      ST_CLK_DLY: begin
        if (src_edge) begin
          cnt_d = cnt_q + 17'h00001;
          if (cnt_q + 17'h00001 >= ck_target) begin
            cnt_d = '0;
            state_d = (rst_path_q && dly != DLY_NONE) ? ST_RST_DLY
                      : ST_RUN;
          end
        end
      end
      ST_RST_DLY: begin
        if (wdt_edge) begin
          cnt_d = cnt_q + 17'h00001;
          if (cnt_q + 17'h00001 >= dly_target) begin
            cnt_d = '0;
            state_d = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        rst_path_d = 1'h0;
        if (sleep_req) state_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (wake) state_d = deep_mode ? ST_CLK_DLY : ST_RUN;
      end
      default: state_d = ST_SAMPLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_SAMPLE;
      cnt_q <= '0;
      rst_path_q <= 1'h1;
      mode_q <= SLP_IDLE;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rst_path_q <= rst_path_d;
      if (state_q == ST_RUN && sleep_req) begin
        mode_q <= csss_sleep_type'(sleep_mode);
      end
    end
  end

  // ---------------------------------------------------------------
  // avalon-mm slave and registers
  // ---------------------------------------------------------------
  logic pll_enable_bit_q;
  logic lock_q;
  logic sat_q;
  csss_pll_if pl();

  wire req = avs_read || avs_write;
  wire accept = req && !avs_waitrequest;
  wire hit_csr = (avs_address == PLL_CSR_OFS);
  wire hit_st = (avs_address == STATUS_OFS);
  wire [31:0] csr_word = 32'({sat_q, t1_clk_sel_q, pll_enable_bit_q, lock_q});
  wire [31:0] st_word =
    (32'(lock_q ? PLL_MULT : 8'h00) << ST_MULT_LSB) |
    (32'(sat_q ? PCK_SAT_MHZ : 8'h00) << ST_SAT_LSB) |
    (32'(state_q) << ST_FSM_LSB) | (32'(amp_range_q) << ST_AMP_LSB) |
    (32'(osc_out_own_q) << ST_OWN_OUT) |
    (32'(osc_in_own_q) << ST_OWN_IN) | (32'(clk_src_q) << ST_SRC_LSB);
  wire [31:0] rd_mux = hit_csr ? csr_word : hit_st ? st_word : 32'h0;
  wire csr_wr = accept && avs_write && hit_csr && avs_byteenable[0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'h1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (req && avs_waitrequest) avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_enable_bit_q <= 1'h0;
      t1_clk_sel_q <= 2'h0;
    end else if (csr_wr) begin
      pll_enable_bit_q <= avs_writedata[PLL_ENABLE_BIT_BIT];
      t1_clk_sel_q <= avs_writedata[T1SEL_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'h0;
      sat_q <= 1'h0;
    end else begin
      lock_q <= pl.locked;
      sat_q <= pl.saturated;
    end
  end

  // ---------------------------------------------------------------
  // pll control
  // ---------------------------------------------------------------
  // enable bit or fuse
  wire pll_want = pll_enable_bit_q || !fz_pk_q;
  // deep sleep stops rc
  // next sleep mode, so an old deep mode cannot stop rc on idle entry
  wire [1:0] mode_nx = (state_q == ST_RUN && sleep_req) ?
                       sleep_mode : mode_q;
  wire rc_on_d = !(state_d == ST_SLEEP && mode_nx[1]);
  wire pll_run_d = pll_want && rc_on_d && (state_q != ST_SAMPLE);

  assign pl.ref_div = (src == SRC_INT_RC) ?
                      2'(fz_cs_q[1:0] - 2'h1) : 2'h0;
  assign pl.run = pll_run_q;
  assign pl.rc_tick = rc_edge;
  assign pl.over_nominal = over_nom;

  csss_pll #(
    .LOCK_REFS(LOCK_REFS)
  ) u_pll (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pl(pl.pll)
  );

  // ---------------------------------------------------------------
  // clock gating and pin ownership
  // ---------------------------------------------------------------
  wire run_d = (state_d == ST_RUN);
  wire slp_d = (state_d == ST_SLEEP);
  csss_sleep_type mode_n;
  assign mode_n = csss_sleep_type'(mode_nx);
  wire io_d = run_d || (slp_d && mode_n == SLP_IDLE);
  wire adc_d = io_d || (slp_d && mode_n == SLP_ADC_NR);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_clk_en_q <= 1'h0;
      flash_clk_en_q <= 1'h0;
      io_clk_en_q <= 1'h0;
      adc_clk_en_q <= 1'h0;
      async_irq_sense_q <= 1'h1;
      rc_osc_en_q <= 1'h1;
      pll_run_q <= 1'h0;
    end else begin
      core_clk_en_q <= run_d;
      flash_clk_en_q <= run_d;
      io_clk_en_q <= io_d;
      async_irq_sense_q <= !io_d;
      adc_clk_en_q <= adc_d;
      rc_osc_en_q <= rc_on_d;
      pll_run_q <= pll_run_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_src_q <= 3'h1;
      osc_in_own_q <= 1'h0;
      osc_out_own_q <= 1'h0;
      amp_range_q <= AMP_NONE;
    end else begin
      clk_src_q <= src;
      osc_in_own_q <= !(src == SRC_INT_RC || src == SRC_PLL);
      osc_out_own_q <= (src == SRC_XTAL || src == SRC_LF_XTAL);
      amp_range_q <= (src != SRC_XTAL) ? AMP_NONE :
                     (fz_cs_q[3:1] == 3'h5) ? AMP_LOW :
                     (fz_cs_q[3:1] == 3'h6) ? AMP_MID : AMP_HIGH;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_deep_sleep;
    state_q == ST_SLEEP && deep_mode ##1 state_q == ST_SLEEP;
  endsequence

  sequence s_deep_wake;
    state_q == ST_SLEEP && deep_mode && wake;
  endsequence

  core_gate_a: assert property (
    core_clk_en_q |-> $past(state_d) == ST_RUN)
    else $error("core clock on outside run");

  irq_sense_a: assert property (
    (state_q == ST_SLEEP && mode_q != SLP_IDLE && !wake)
      |=> async_irq_sense_q && !io_clk_en_q)
    else $error("async sense off while io clock gated");

  flash_core_a: assert property (
    flash_clk_en_q == core_clk_en_q)
    else $error("flash clock differs from core clock");

  adc_quiet_a: assert property (
    (state_q == ST_SLEEP && mode_q == SLP_ADC_NR && !wake)
      |=> adc_clk_en_q && !io_clk_en_q && !core_clk_en_q)
    else $error("noise reduction gating wrong");

  pll_enable_a: assert property (
    pll_run_q |-> $past(pll_enable_bit_q) || !$past(fz_pk_q))
    else $error("pll runs while not enabled");

  deep_off_a: assert property (
    s_deep_sleep |-> !rc_osc_en_q && !pll_run_q)
    else $error("rc or pll on in deep sleep");

  pin_own_a: assert property (
    $stable(src) [*2] |-> osc_out_own_q ==
      (src == SRC_XTAL || src == SRC_LF_XTAL))
    else $error("output pin ownership wrong");

  wake_wait_a: assert property (
    s_deep_wake |=> state_q == ST_CLK_DLY ##1 !core_clk_en_q)
    else $error("deep wake skipped start-up count");

  fuse_hold_a: assert property (
    $changed(fz_cs_q) |-> $past(state_q) == ST_SAMPLE)
    else $error("fuses changed outside reset");

endmodule // csss_top

// File: tb/csss_top_test.sv
module csss_top_test
  import csss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W4 = 4;
  localparam int W64 = 8;
  localparam int C16 = 5;
  localparam int C32 = 6;
  logic sys_clk = 0, rst_n = 0, pll_clock_fuse = 1, src_tick = 0;
  logic wdt_tick = 0, rc_tick = 0, wake_irq = 0, ref_above_nominal = 0;
  logic sleep_req = 0, avs_read = 0, avs_write = 0;
  logic [3:0] clock_source_fuses = 4'h1, avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [1:0] startup_time_fuses = 2'h2, sleep_mode = 2'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, core_clk_en_q, io_clk_en_q, flash_clk_en_q;
  logic adc_clk_en_q, async_irq_sense_q, rc_osc_en_q, pll_run_q;
  logic [1:0] t1_clk_sel_q, amp_range_q;
  logic [2:0] clk_src_q;
  logic osc_in_own_q, osc_out_own_q;
  int fails = 0, check_count = 0, n;

  csss_top #(.WDT_4K_CYC(W4), .WDT_64K_CYC(W64), .CK_16K_CYC(C16),
    .CK_32K_CYC(C32), .LOCK_REFS(2)) dut (
    .sys_clk, .rst_n, .pll_clock_fuse, .clock_source_fuses,
    .startup_time_fuses, .src_tick, .wdt_tick, .rc_tick, .wake_irq,
    .ref_above_nominal, .sleep_req, .sleep_mode, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .core_clk_en_q, .io_clk_en_q, .flash_clk_en_q,
    .adc_clk_en_q, .async_irq_sense_q, .rc_osc_en_q, .pll_run_q,
    .t1_clk_sel_q, .clk_src_q, .osc_in_own_q, .osc_out_own_q,
    .amp_range_q);

  // ------------------------------------------------------------
  // clocks and oscillator ticks
  // ------------------------------------------------------------
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    src_tick <= ~src_tick;
    wdt_tick <= ~wdt_tick;
    rc_tick <= ~rc_tick;
  end

  // ------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------
  function automatic logic [2:0] e_src(logic p, logic [3:0] c);
    if (!p) return c == 4'h1 ? SRC_PLL : SRC_INT_RC;
    if (c == 4'h0) return SRC_EXT_CLK;
    if (c <= 4'h4) return SRC_INT_RC;
    if (c <= 4'h8) return SRC_EXT_RC;
    return c == 4'h9 ? SRC_LF_XTAL : SRC_XTAL;
  endfunction

  // lower bound in cycles: each tick edge comes every 2 cycles
  function automatic int e_cyc(logic p, logic [3:0] c, logic [1:0] s);
    logic [2:0] t;
    int ns, nw;
    t = {c[0], s};
    ns = 6;
    nw = s == 2'h0 ? 0 : s == 2'h1 ? W4 : W64;
    case (e_src(p, c))
      SRC_XTAL: begin
        ns = t < 2 ? 258 : t < 5 ? 1024 : C16;
        nw = t inside {2, 5} ? 0 : t inside {0, 3, 6} ? W4 : W64;
      end
      SRC_EXT_RC: begin
        ns = s == 2'h3 ? 6 : 18;
        nw = s == 2'h0 ? 0 : s == 2'h2 ? W64 : W4;
      end
      SRC_LF_XTAL: begin
        ns = s[1] ? C32 : 1024;
        nw = s == 2'h0 ? W4 : W64;
      end
      default: ;
    endcase
    return 2 * (ns + nw);
  endfunction

  // ------------------------------------------------------------
  // compare, bus and reset tasks
  // ------------------------------------------------------------
  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic chk_rng(int got, int lo, int hi, string m);
    check_count++;
    if (got < lo || got > hi) begin
      fails++;
      $display("unexpected at %0t: %s took %0d cycles", $time, m, got);
    end
  endtask

  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    if (k >= 20) chk(0, 1, "bus answer");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic boot(logic p, logic [3:0] c, logic [1:0] s);
    logic [2:0] e;
    e = e_src(p, c);
    rst_n <= 1'b0;
    pll_clock_fuse <= p;
    clock_source_fuses <= c;
    startup_time_fuses <= s;
    repeat (2) @(posedge sys_clk);
    chk(clk_src_q, SRC_INT_RC, "reset source");
    chk(core_clk_en_q, 0, "reset core");
    rst_n <= 1'b1;
    n = 0;
    while (core_clk_en_q !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    chk_rng(n, e_cyc(p, c, s), e_cyc(p, c, s) + 20, "start");
    chk(clk_src_q, e, "source");
    chk(osc_in_own_q, !(e inside {SRC_INT_RC, SRC_PLL}), "in pin");
    chk(osc_out_own_q, e inside {SRC_LF_XTAL, SRC_XTAL}, "out pin");
    chk(amp_range_q, e == SRC_XTAL ? 2'(c[3:1] - 3'h5) : AMP_NONE,
      "amp");
    chk(adc_clk_en_q & io_clk_en_q & flash_clk_en_q, 1, "run");
    $display("test boot %0d %0h %0h done", p, c, s);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #(50 * 80000);
    fails++;
    finish_test();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(56));
    boot(1'b1, 4'h1, 2'h2);
    clock_source_fuses <= 4'hF;
    pll_clock_fuse <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(clk_src_q, SRC_INT_RC, "late fuse");
    chk(pll_run_q, 0, "late pll fuse");
    boot(1'b1, 4'hA, 2'h0);
    boot(1'b1, 4'hA, 2'h1);
    boot(1'b1, 4'h7, 2'h3);
    for (int i = 0; i < 17; i++)
      boot(i < 16, i < 16 ? 4'(i) : 4'h1, 2'($urandom));
    chk(pll_run_q, 1, "pll by fuse");
    for (int m = 0; m < 4; m++) begin
      sleep_req <= 1'b1;
      sleep_mode <= 2'(m);
      @(posedge sys_clk);
      sleep_req <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk(core_clk_en_q | flash_clk_en_q, 0, "core gate");
      chk(io_clk_en_q, m == 0, "io gate");
      chk(async_irq_sense_q, m != 0, "async sense");
      chk(adc_clk_en_q, m < 2, "adc gate");
      chk({rc_osc_en_q, pll_run_q}, m < 2 ? 2'h3 : 2'h0, "osc stop");
      wake_irq <= 1'b1;
      n = 0;
      while (core_clk_en_q !== 1'b1 && n < 200) begin
        @(posedge sys_clk);
        n++;
      end
      wake_irq <= 1'b0;
      chk_rng(n, m < 2 ? 0 : 12, m < 2 ? 8 : 30, "wake");
      repeat (4) @(posedge sys_clk);
    end
    $display("test sleep done");
    boot(1'b1, 4'h1, 2'h0);
    chk(pll_run_q, 0, "pll off");
    bus(1'b1, PLL_CSR_OFS, 32'h0000000A);
    repeat (20) @(posedge sys_clk);
    chk(pll_run_q, 1, "pll on");
    chk(t1_clk_sel_q, 2'h2, "timer select");
    bus(1'b0, PLL_CSR_OFS, 32'h0);
    chk(rd, 32'h0000000B, "csr");
    bus(1'b0, STATUS_OFS, 32'h0);
    chk(rd[ST_MULT_LSB +: 8], PLL_MULT, "multiplier");
    bus(1'b1, PLL_CSR_OFS, 32'h00000002);
    bus(1'b0, PLL_CSR_OFS, 32'h0);
    chk(rd, 32'h00000003, "read only lock");
    avs_byteenable <= 4'h0;
    bus(1'b1, PLL_CSR_OFS, 32'h0);
    avs_byteenable <= 4'hF;
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0, "unmapped");
    chk(pll_run_q, 1, "masked write");
    ref_above_nominal <= 1'b1;
    repeat (10) @(posedge sys_clk);
    bus(1'b0, PLL_CSR_OFS, 32'h0);
    chk(rd[SAT_BIT], 1, "saturated");
    chk(rd[LOCK_BIT], 0, "unlocked");
    bus(1'b0, STATUS_OFS, 32'h0);
    chk(rd[ST_SAT_LSB +: 8], PCK_SAT_MHZ, "ceiling");
    ref_above_nominal <= 1'b0;
    repeat (12) @(posedge sys_clk);
    bus(1'b0, PLL_CSR_OFS, 32'h0);
    chk(rd, 32'h00000003, "relock");
    bus(1'b1, PLL_CSR_OFS, 32'h0);
    repeat (4) @(posedge sys_clk);
    chk(pll_run_q, 0, "pll disabled");
    $display("test pll done");
    finish_test();
  end
endmodule // csss_top_test
